// *** src/ubd_pkg.sv ***
package ubd_pkg;

	// ***************************************************************
	// register map
	// ***************************************************************
	localparam logic [11:0] UBD_CTL_OFF       = 12'h080;
	localparam logic [11:0] UBD_LINK_CFG_OFF  = 12'h084;
	localparam logic [11:0] UBD_DETACH_OFF    = 12'h088;
	localparam logic [11:0] UBD_STATUS_OFF    = 12'h08C;
	localparam logic [11:0] UBD_BURST_OFF     = 12'h090;
	localparam logic [11:0] UBD_SPD_OFF       = 12'h094;

	// control: bit 0 burst limit enable, bit 1 soft reset (self clears)
	localparam int UBD_CTL_BURST_EN_BIT = 0;
	localparam int UBD_CTL_SOFT_RST_BIT = 1;
	// link config and detach field positions
	localparam int UBD_LC_SCALE_LSB = 0;
	localparam int UBD_LC_FS_CAL_LSB = 4;
	localparam int UBD_LC_LTM_BIT = 8;
	localparam int UBD_LC_U1_BIT = 9;
	localparam int UBD_LC_HS_CAL_LSB = 12;
	localparam int UBD_DET_SS_LSB = 16;

	// ***************************************************************
	// reset and fallback values
	// ***************************************************************
	localparam logic [1:0]  UBD_SCALE_RST      = 2'h0;
	localparam logic [7:0]  UBD_BURST_RST      = 8'h00;
	localparam logic [15:0] UBD_SPD_RST        = 16'h0800;
	localparam logic [15:0] UBD_SS_DETACH_DFLT = 16'h001E;
	localparam logic [15:0] UBD_HIGHSPEED_DETACH_MS_DFLT = 16'h000A;
	localparam logic [2:0]  UBD_CAL_DFLT       = 3'h0;
	localparam logic        UBD_LTM_DFLT       = 1'b0;
	localparam logic        UBD_U1_DFLT        = 1'b1;

	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int UBD_CLK_NS = 10;
	localparam int UBD_MS_NS = 1000000;
	localparam int UBD_MS_CYCLES = UBD_MS_NS / UBD_CLK_NS;
	// 16.667 ns unit: 10 ns / 16.667 ns = 3/5, so add 3 modulo 5
	localparam logic [2:0] UBD_UNIT_ADD = 3'h3;
	localparam logic [2:0] UBD_UNIT_MOD = 3'h5;
	localparam int UBD_POLL_SCALED_NS = 100;
	localparam int UBD_WARM_SCALED_US = 30;
	localparam int UBD_POLL_SCALED_CYC =
		(UBD_POLL_SCALED_NS + UBD_CLK_NS - 1) / UBD_CLK_NS;
	localparam int UBD_WARM_SCALED_CYC =
		(UBD_WARM_SCALED_US * 1000 + UBD_CLK_NS - 1) / UBD_CLK_NS;
	localparam logic [15:0] UBD_TXEQ_SCALED = 16'h0008;
	localparam int UBD_MIN_BURST_BYTES = 2048;
	localparam int UBD_SS_UNIT_SHIFT = 10;
	localparam int UBD_HS_UNIT_SHIFT = 9;
	localparam int UBD_FS_UNIT_SHIFT = 6;

	// ***************************************************************
	// types
	// ***************************************************************
	typedef enum logic [1:0] {
		UBD_SPD_LOW,
		UBD_SPD_FULL,
		UBD_SPD_HIGH,
		UBD_SPD_SUPER
	} ubd_speed_t;

	typedef struct packed {
		logic [15:0] ss_detach;
		logic [15:0] highspeed_detach_ms;
		logic [2:0]  hs_timeout_calibration;
		logic [2:0]  fs_timeout_calibration;
		logic        latency_msg_enable;
		logic        host_u1_accept;
	} ubd_image_t;

	localparam ubd_image_t UBD_IMAGE_DFLT = '{
		ss_detach:              UBD_SS_DETACH_DFLT,
		highspeed_detach_ms:    UBD_HIGHSPEED_DETACH_MS_DFLT,
		hs_timeout_calibration: UBD_CAL_DFLT,
		fs_timeout_calibration: UBD_CAL_DFLT,
		latency_msg_enable:     UBD_LTM_DFLT,
		host_u1_accept:         UBD_U1_DFLT
	};

	typedef struct packed {
		logic [15:0] txeq_len;
		logic [15:0] poll_cycles;
		logic [15:0] warm_rx_cycles;
		logic        scale_general;
		logic        scale_suspend;
	} ubd_timing_t;

endpackage

// *** src/ubd_detach_config.sv ***
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module ubd_detach_config
	import ubd_pkg::*;
#(
	parameter int MS_CYCLES        = UBD_MS_CYCLES,
	parameter logic [15:0] TXEQ_FULL = 16'hFFFF,
	parameter logic [15:0] POLL_FULL = 16'h0100,
	parameter logic [15:0] WARM_FULL = 16'hFFFF
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        eeprom_present,
	input  wire logic        otp_present,
	input  ubd_image_t       eeprom_image,
	input  ubd_image_t       otp_image,
	input  wire logic        image_load,
	input  wire logic        usb_reset,
	input  wire logic        lite_reset,
	input  wire logic        rst_protect,
	input  ubd_speed_t       link_speed,
	input  wire logic        pkt_sent,
	input  wire logic [10:0] pkt_bytes,
	input  wire logic        pkt_short,
	input  wire logic        short_req,
	output logic             burst_end,
	output logic             short_go,
	output logic             detached,
	output logic [2:0]       tout_cal,
	output logic             latency_msg_enable,
	output logic             host_u1_accept,
	output ubd_timing_t      timing
);

	// ***************************************************************
	// configuration image and registers
	// ***************************************************************
	ubd_image_t  img_ff;
	ubd_image_t  nxt_img;
	ubd_image_t  sel_image;
	logic        load_pend_ff;
	logic [1:0]  scale_ff;
	logic        burst_en_ff;
	logic [7:0]  burst_limit_ff;
	logic [15:0] short_packet_delay_ff;
	logic        wr_ff;
	logic [11:0] addr_ff;
	logic        rd_wait_ff;
	logic        soft_rst_pulse;
	logic        restore;

	assign sel_image = eeprom_present ? eeprom_image :
		otp_present ? otp_image : UBD_IMAGE_DFLT;
	assign restore = usb_reset | lite_reset;
	assign soft_rst_pulse = wr_ff && addr_ff == UBD_CTL_OFF &&
		hwdata[UBD_CTL_SOFT_RST_BIT];
	always_comb begin
		nxt_img = img_ff;
		if (load_pend_ff || image_load) begin
			nxt_img = sel_image;
		end else if (restore) begin
			// reload the currently selected image; protected fields keep value
			nxt_img.hs_timeout_calibration = sel_image.hs_timeout_calibration;
			nxt_img.fs_timeout_calibration = sel_image.fs_timeout_calibration;
			if (!rst_protect) begin
				nxt_img.ss_detach = sel_image.ss_detach;
				nxt_img.highspeed_detach_ms = sel_image.highspeed_detach_ms;
				nxt_img.latency_msg_enable = sel_image.latency_msg_enable;
				nxt_img.host_u1_accept = sel_image.host_u1_accept;
			end
		end else if (wr_ff && addr_ff == UBD_DETACH_OFF) begin
			nxt_img.ss_detach = hwdata[UBD_DET_SS_LSB +: 16];
			nxt_img.highspeed_detach_ms = hwdata[15:0];
		end else if (wr_ff && addr_ff == UBD_LINK_CFG_OFF) begin
			nxt_img.fs_timeout_calibration = hwdata[UBD_LC_FS_CAL_LSB +: 3];
			nxt_img.hs_timeout_calibration = hwdata[UBD_LC_HS_CAL_LSB +: 3];
			nxt_img.latency_msg_enable = hwdata[UBD_LC_LTM_BIT];
			nxt_img.host_u1_accept = hwdata[UBD_LC_U1_BIT];
		end
	end

	// image pins are sampled one edge after reset release, not in reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			img_ff <= UBD_IMAGE_DFLT;
			load_pend_ff <= 1'b1;
		end else begin
			img_ff <= nxt_img;
			load_pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scale_ff <= UBD_SCALE_RST;
			burst_en_ff <= 1'b0;
			burst_limit_ff <= UBD_BURST_RST;
			short_packet_delay_ff <= UBD_SPD_RST;
		end else if (wr_ff) begin
			unique case (addr_ff)
				UBD_LINK_CFG_OFF: scale_ff <= hwdata[UBD_LC_SCALE_LSB +: 2];
				UBD_CTL_OFF: burst_en_ff <= hwdata[UBD_CTL_BURST_EN_BIT];
				UBD_BURST_OFF: burst_limit_ff <= hwdata[7:0];
				UBD_SPD_OFF: short_packet_delay_ff <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	// ***************************************************************
	// AHB-Lite slave: writes zero wait, reads one wait state
	// ***************************************************************
	// the read wait keeps a read after a write from seeing stale data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff <= 1'b0;
			addr_ff <= 12'h000;
		end else if (hready) begin
			wr_ff <= hsel && htrans[1] && hwrite;
			addr_ff <= {haddr[11:2], 2'b00};
		end
	end
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (addr_ff)
			UBD_CTL_OFF: rd_mux[UBD_CTL_BURST_EN_BIT] = burst_en_ff;
			UBD_LINK_CFG_OFF: begin
				rd_mux[UBD_LC_SCALE_LSB +: 2] = scale_ff;
				rd_mux[UBD_LC_FS_CAL_LSB +: 3] = img_ff.fs_timeout_calibration;
				rd_mux[UBD_LC_LTM_BIT] = img_ff.latency_msg_enable;
				rd_mux[UBD_LC_U1_BIT] = img_ff.host_u1_accept;
				rd_mux[UBD_LC_HS_CAL_LSB +: 3] = img_ff.hs_timeout_calibration;
			end
			UBD_DETACH_OFF:
				rd_mux = {img_ff.ss_detach, img_ff.highspeed_detach_ms};
			UBD_STATUS_OFF: rd_mux[2:0] = {link_speed, detached};
			UBD_BURST_OFF: rd_mux[7:0] = burst_limit_ff;
			UBD_SPD_OFF: rd_mux[15:0] = short_packet_delay_ff;
			default: ;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			rd_wait_ff <= 1'b0;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite) begin
				hreadyout <= 1'b0;
				rd_wait_ff <= 1'b1;
			end else if (rd_wait_ff) begin
				hreadyout <= 1'b1;
				rd_wait_ff <= 1'b0;
				hrdata <= rd_mux;
			end
		end
	end

	// ***************************************************************
	// tick dividers
	// ***************************************************************
	logic [2:0]  phase_ff;
	logic [3:0]  phase_sum;
	logic        unit_tick;
	logic [31:0] ms_div_ff;
	logic        ms_tick;
	assign phase_sum = {1'b0, phase_ff} + {1'b0, UBD_UNIT_ADD};
	assign unit_tick = phase_sum >= {1'b0, UBD_UNIT_MOD};
	assign ms_tick = ms_div_ff == 32'(MS_CYCLES - 1);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_ff <= 3'h0;
		end else if (unit_tick) begin
			phase_ff <= 3'(phase_sum - {1'b0, UBD_UNIT_MOD});
		end else begin
			phase_ff <= phase_sum[2:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ms_div_ff <= 32'h0000_0000;
		end else if (ms_tick || soft_rst_pulse) begin
			ms_div_ff <= 32'h0000_0000;
		end else begin
			ms_div_ff <= ms_div_ff + 32'h0000_0001;
		end
	end

	// ***************************************************************
	// soft reset detach timer
	// ***************************************************************
	logic [15:0] detach_cnt_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			detach_cnt_ff <= 16'h0000;
			detached <= 1'b0;
		end else if (soft_rst_pulse) begin
			if (link_speed == UBD_SPD_SUPER) begin
				detach_cnt_ff <= img_ff.ss_detach;
				detached <= img_ff.ss_detach != 16'h0000;
			end else begin
				detach_cnt_ff <= img_ff.highspeed_detach_ms;
				detached <= img_ff.highspeed_detach_ms != 16'h0000;
			end
		end else if (ms_tick && detach_cnt_ff != 16'h0000) begin
			detach_cnt_ff <= detach_cnt_ff - 16'h0001;
			detached <= detach_cnt_ff != 16'h0001;
		end
	end

	// ***************************************************************
	// bulk-in burst limit
	// ***************************************************************
	logic [18:0] limit_bytes;
	logic [18:0] contig_ff;
	logic [18:0] contig_sum;
	logic        limit_on;
	always_comb begin
		unique case (link_speed)
			UBD_SPD_SUPER:
				limit_bytes = 19'({11'h000, burst_limit_ff} << UBD_SS_UNIT_SHIFT);
			UBD_SPD_HIGH:
				limit_bytes = 19'({11'h000, burst_limit_ff} << UBD_HS_UNIT_SHIFT);
			default:
				limit_bytes = 19'({11'h000, burst_limit_ff} << UBD_FS_UNIT_SHIFT);
		endcase
	end
	assign limit_on = burst_en_ff &&
		limit_bytes > 19'(UBD_MIN_BURST_BYTES);
	assign contig_sum = contig_ff + {8'h00, pkt_bytes};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			contig_ff <= 19'h00000;
			burst_end <= 1'b0;
		end else begin
			burst_end <= 1'b0;
			if (pkt_sent) begin
				if (pkt_short || !limit_on) begin
					contig_ff <= 19'h00000;
				end else if (contig_sum >= limit_bytes) begin
					contig_ff <= 19'h00000;
					burst_end <= 1'b1;
				end else begin
					contig_ff <= contig_sum;
				end
			end
		end
	end

	// ***************************************************************
	// short packet delay
	// ***************************************************************
	logic [15:0] spd_cnt_ff;
	logic        spd_busy_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			spd_cnt_ff <= 16'h0000;
			spd_busy_ff <= 1'b0;
			short_go <= 1'b0;
		end else begin
			short_go <= 1'b0;
			if (short_req && !spd_busy_ff) begin
				spd_cnt_ff <= short_packet_delay_ff;
				spd_busy_ff <= 1'b1;
			end else if (spd_busy_ff) begin
				if (spd_cnt_ff == 16'h0000) begin
					spd_busy_ff <= 1'b0;
					short_go <= 1'b1;
				end else if (unit_tick) begin
					spd_cnt_ff <= spd_cnt_ff - 16'h0001;
				end
			end
		end
	end

	// ***************************************************************
	// link timing outputs
	// ***************************************************************
	// scale-down is meant for simulation; hardware leaves it at zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timing <= '{TXEQ_FULL, POLL_FULL, WARM_FULL, 1'b0, 1'b0};
			tout_cal <= UBD_CAL_DFLT;
			latency_msg_enable <= UBD_LTM_DFLT;
			host_u1_accept <= UBD_U1_DFLT;
		end else begin
			timing.scale_general <= scale_ff[0];
			timing.scale_suspend <= scale_ff[1];
			timing.txeq_len <= scale_ff[1] ? 16'h0000 :
				scale_ff[0] ? UBD_TXEQ_SCALED : TXEQ_FULL;
			timing.poll_cycles <= scale_ff[0] ?
				16'(UBD_POLL_SCALED_CYC) : POLL_FULL;
			timing.warm_rx_cycles <= scale_ff[0] ?
				16'(UBD_WARM_SCALED_CYC) : WARM_FULL;
			tout_cal <= link_speed == UBD_SPD_FULL ?
				img_ff.fs_timeout_calibration :
				img_ff.hs_timeout_calibration;
			latency_msg_enable <= img_ff.latency_msg_enable;
			host_u1_accept <= img_ff.host_u1_accept;
		end
	end

endmodule

// *** verification/ubd_host_model.sv ***
`timescale 1ns/10ps
module ubd_host_model
	import ubd_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        burst_end,
	input  wire logic        short_go,
	output logic             pkt_sent,
	output logic [10:0]      pkt_bytes,
	output logic             pkt_short,
	output logic             short_req
);
	int pkts;
	int end_at;
	int gap;

	initial begin
		pkt_sent = 1'b0;
		pkt_bytes = 11'h7FF;
		pkt_short = 1'b0;
		short_req = 1'b0;
		pkts = 0;
		end_at = 0;
		gap = 0;
	end

	// first packet that closed the burst
	always @(posedge hclk) begin
		if (burst_end && end_at == 0) begin
			end_at = pkts;
		end
	end

	task automatic clear();
		pkts = 0;
		end_at = 0;
	endtask

	task automatic send(input logic [10:0] n, input logic s);
		@(posedge hclk);
		pkt_sent <= 1'b1;
		pkt_bytes <= n;
		pkt_short <= s;
		@(posedge hclk);
		pkts++;
		pkt_sent <= 1'b0;
		// released lines never keep the old length
		pkt_bytes <= ~n;
		pkt_short <= ~s;
		repeat (gap) @(posedge hclk);
	endtask

	task automatic short_wait(output int c);
		@(posedge hclk);
		short_req <= 1'b1;
		@(posedge hclk);
		short_req <= 1'b0;
		c = 0;
		do begin
			@(negedge hclk);
			c++;
		end while (!short_go && c < 4000);
	endtask
endmodule

// *** verification/ubd_detach_config_checker.sv ***
`timescale 1ns/10ps
module ubd_detach_config_checker
	import ubd_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        pkt_sent,
	input wire logic        pkt_short,
	input wire logic        burst_end,
	input wire logic        short_go,
	input ubd_timing_t      timing
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_resp_okay: assert property (hresp == 1'b0)
		else $error("slave error response");
	a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
		|=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
	a_burst_pulse: assert property (burst_end |=> !burst_end)
		else $error("burst end too long");
	a_burst_cause: assert property (burst_end |-> $past(pkt_sent))
		else $error("burst end without packet");
	a_short_no_end: assert property (
		pkt_sent && pkt_short |=> !burst_end)
		else $error("short packet ended burst");
	a_short_pulse: assert property (short_go |=> !short_go)
		else $error("short go too long");
	a_txeq_none: assert property (
		timing.scale_suspend |-> timing.txeq_len == 16'h0000)
		else $error("txeq sent while suppressed");
	a_txeq_eight: assert property (
		timing.scale_general && !timing.scale_suspend
		|-> timing.txeq_len == UBD_TXEQ_SCALED)
		else $error("scaled txeq count wrong");
	a_lfps_short: assert property (
		timing.scale_general |-> timing.poll_cycles == 16'h000A
		&& timing.warm_rx_cycles == 16'h0BB8)
		else $error("scaled lfps timing wrong");
endmodule

bind ubd_detach_config ubd_detach_config_checker u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .pkt_sent(pkt_sent), .pkt_short(pkt_short),
	.burst_end(burst_end), .short_go(short_go), .timing(timing)
);

// *** verification/tb_ubd_detach_config.sv ***
`timescale 1ns/10ps
module tb_ubd_detach_config;
	import ubd_pkg::*;

	localparam logic [15:0] TXF = 16'h1234;
	localparam logic [15:0] PLF = 16'h0200;
	localparam logic [15:0] WMF = 16'h4321;
	localparam int          MS  = 20;

	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        eeprom_present, otp_present, rst_protect;
	logic        pkt_sent, pkt_short, short_req, burst_end, short_go;
	logic        detached, latency_msg_enable, host_u1_accept;
	logic [1:0]  htrans;
	logic [2:0]  evt, tout_cal;
	logic [10:0] pkt_bytes;
	logic [31:0] haddr, hwdata, hrdata;
	ubd_image_t  eeprom_image, otp_image;
	ubd_speed_t  link_speed;
	ubd_timing_t timing;
	int          errors, total_checks, cycles;

	ubd_detach_config #(
		.MS_CYCLES(MS), .TXEQ_FULL(TXF), .POLL_FULL(PLF), .WARM_FULL(WMF)
	) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .eeprom_present(eeprom_present),
		.otp_present(otp_present), .eeprom_image(eeprom_image),
		.otp_image(otp_image), .image_load(evt[2]), .usb_reset(evt[1]),
		.lite_reset(evt[0]), .rst_protect(rst_protect),
		.link_speed(link_speed), .pkt_sent(pkt_sent),
		.pkt_bytes(pkt_bytes), .pkt_short(pkt_short),
		.short_req(short_req), .burst_end(burst_end),
		.short_go(short_go), .detached(detached), .tout_cal(tout_cal),
		.latency_msg_enable(latency_msg_enable),
		.host_u1_accept(host_u1_accept), .timing(timing)
	);

	ubd_host_model u_host (
		.hclk(hclk), .burst_end(burst_end), .short_go(short_go),
		.pkt_sent(pkt_sent), .pkt_bytes(pkt_bytes),
		.pkt_short(pkt_short), .short_req(short_req)
	);

	// ********
	// bus and check helpers
	// ********
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task automatic ahb(input logic [11:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (!hreadyout);
		q = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		ahb(a, 1'b0, 32'h0, q);
		chk(q, e);
	endtask

	task automatic pls(input logic [2:0] m);
		@(posedge hclk);
		evt <= m;
		@(posedge hclk);
		evt <= 3'h0;
		repeat (2) @(posedge hclk);
	endtask

	// ********
	// scenarios
	// ********
	task automatic t_defaults();
		rd(UBD_DETACH_OFF, 32'h001E_000A);
		rd(UBD_BURST_OFF, 32'h0000_0000);
		rd(UBD_SPD_OFF, 32'h0000_0800);
		rd(UBD_LINK_CFG_OFF, 32'h0000_0200);
		rd(12'h0A0, 32'h0000_0000);
		chk({latency_msg_enable, host_u1_accept, tout_cal}, 64'h8);
	endtask

	task automatic t_image();
		otp_image <= '{16'h0007, 16'h0005, 3'h6, 3'h2, 1'b1, 1'b0};
		eeprom_image <= '{16'h0009, 16'h0004, 3'h1, 3'h3, 1'b0, 1'b1};
		otp_present <= 1'b1;
		pls(3'h4);
		rd(UBD_DETACH_OFF, 32'h0007_0005);
		rd(UBD_LINK_CFG_OFF, 32'h0000_6120);
		eeprom_present <= 1'b1;
		pls(3'h4);
		rd(UBD_LINK_CFG_OFF, 32'h0000_1230);
		wr(UBD_DETACH_OFF, 32'h1234_5678);
		pls(3'h1);
		rd(UBD_DETACH_OFF, 32'h0009_0004);
		rst_protect <= 1'b1;
		wr(UBD_DETACH_OFF, 32'h0000_ABCD);
		pls(3'h2);
		rd(UBD_DETACH_OFF, 32'h0000_ABCD);
		rst_protect <= 1'b0;
	endtask

	task automatic t_link();
		logic [15:0] tx;
		logic [49:0] e;
		for (int s = 0; s < 4; s++) begin
			wr(UBD_LINK_CFG_OFF, 32'h0000_5030 | s);
			repeat (3) @(posedge hclk);
			tx = s[1] ? 16'h0000 : (s[0] ? UBD_TXEQ_SCALED : TXF);
			e = {tx, s[0] ? 16'h000A : PLF, s[0] ? 16'h0BB8 : WMF, s[0], s[1]};
			chk(timing, e);
		end
		for (int p = 0; p < 4; p++) begin
			link_speed <= ubd_speed_t'(p);
			repeat (3) @(posedge hclk);
			chk(tout_cal, p == 1 ? 3'h3 : 3'h5);
		end
		wr(UBD_LINK_CFG_OFF, 32'h0000_5030);
	endtask

	task automatic bcase(input ubd_speed_t sp, input logic en,
		input logic [7:0] lim, input int exp);
		link_speed <= sp;
		wr(UBD_CTL_OFF, {31'h0, en});
		wr(UBD_BURST_OFF, {24'h0, lim});
		u_host.send(11'h000, 1'b1);
		u_host.clear();
		repeat (7) u_host.send(11'h200, 1'b0);
		repeat (2) @(posedge hclk);
		chk(u_host.end_at, exp);
	endtask

	task automatic t_burst();
		bcase(UBD_SPD_HIGH, 1'b1, 8'h05, 5);
		bcase(UBD_SPD_SUPER, 1'b1, 8'h03, 6);
		u_host.gap = 3;
		bcase(UBD_SPD_FULL, 1'b1, 8'h28, 5);
		u_host.gap = 0;
		bcase(UBD_SPD_HIGH, 1'b1, 8'h04, 0);
		bcase(UBD_SPD_HIGH, 1'b0, 8'h05, 0);
	endtask

	task automatic t_short();
		int c;
		wr(UBD_SPD_OFF, 32'h0000_001E);
		u_host.short_wait(c);
		chk(c > 48 && c < 54, 64'h1);
		wr(UBD_SPD_OFF, 32'h0000_0000);
		u_host.short_wait(c);
		chk(c, 64'h2);
	endtask

	task automatic dcase(input ubd_speed_t sp, input int exp);
		int c;
		link_speed <= sp;
		wr(UBD_CTL_OFF, 32'h0000_0002);
		for (c = 0; c < 5 && !detached; c++) @(negedge hclk);
		c = 0;
		while (detached && c < 5000) begin
			@(negedge hclk);
			c++;
		end
		chk(c >= exp && c <= exp + 2, 64'h1);
	endtask

	task automatic t_detach();
		wr(UBD_DETACH_OFF, 32'h0003_0002);
		dcase(UBD_SPD_SUPER, 3 * MS);
		dcase(UBD_SPD_HIGH, 2 * MS);
		dcase(UBD_SPD_FULL, 2 * MS);
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always #5 hclk = ~hclk;

	// hang guard, far above the expected run length
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("mismatch at %0t: run timed out", $time);
			finish_test();
		end
	end

	initial begin
		{hclk, hresetn, hsel, hwrite, evt, htrans} = '0;
		{eeprom_present, otp_present, rst_protect} = '0;
		{haddr, hwdata, eeprom_image, otp_image} = '0;
		link_speed = UBD_SPD_HIGH;
		{errors, total_checks, cycles} = '0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_defaults();
		t_image();
		t_link();
		t_burst();
		t_short();
		t_detach();
		finish_test();
	end
endmodule
